/* dv/qss_shift_register_bench.sv */
// Self-checking bench for the four-section serial shift register.
// Assumes the upstream model and a 50 MHz clock; stages start unknown.
`timescale 1ns/1ps
`default_nettype none

module qss_shift_register_bench;
    typedef struct packed {
        logic [3:0] din;
        logic [3:0] out;
        logic [1:0] tap;
    } qss_row_t;

    // Expected after each fall, from a zero-flushed register
    localparam qss_row_t ROWS [8] = '{'{4'h1, 4'h0, 2'h0}, '{4'h2, 4'h0, 2'h0},
        '{4'h4, 4'h0, 2'h0}, '{4'h8, 4'h1, 2'h0}, '{4'hf, 4'h2, 2'h0},
        '{4'h0, 4'h0, 2'h1}, '{4'h5, 4'h4, 2'h2}, '{4'ha, 4'hb, 2'h3}};
    localparam int LIMIT = 2000;

    logic       clk;
    logic       resetn;
    logic       outReady;
    logic       shiftClk;
    logic [3:0] serialIn;
    logic       inReady;
    logic [3:0] sectionOut;
    logic [1:0] fourthTap;
    logic       halfTap;
    logic       prevHalf;
    int         failures;
    int         tests_run;
    int         cycles;

    qss_shift_register dut (.clk(clk), .resetn(resetn), .shiftClk(shiftClk),
        .serialIn(serialIn), .inReady(inReady), .outReady(outReady),
        .sectionOut(sectionOut), .fourthTap(fourthTap), .halfTap(halfTap));

    qss_upstream up (.clk(clk), .inReady(inReady), .shiftClk(shiftClk), .serialIn(serialIn));

    initial clk = 1'h0;
    always #10 clk = ~clk;

    // ========================================================
    // Reporting
    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Pop and stage update take one edge after the push; three leaves margin
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            report_and_stop();
        end
    end

    // ========================================================
    // Main sequence
    initial begin
        failures = 0;
        tests_run = 0;
        cycles = 0;
        resetn = 1'h0;
        outReady = 1'h1;
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'h1;
        repeat (5) begin
            up.drive(1'h1, 4'h0);
            up.drive(1'h0, 4'h0);
        end
        up.drive(1'h1, 4'h0);
        settle();
        prevHalf = 1'h0;
        foreach (ROWS[i]) begin
            up.drive(1'h0, ROWS[i].din);
            settle();
            check("sectionOut", ROWS[i].out, sectionOut);
            check("fourthTap", {2'h0, ROWS[i].tap}, {2'h0, fourthTap});
            check("halfTap lag", {3'h0, prevHalf}, {3'h0, halfTap});
            up.drive(1'h1, 4'h0);
            settle();
            check("halfTap", {3'h0, ROWS[i].tap[0]}, {3'h0, halfTap});
            prevHalf = ROWS[i].tap[0];
        end
        // Fill the event queue while stalled; nothing may shift meanwhile
        outReady = 1'h0;
        for (int i = 0; i < 16; i++) begin
            up.drive(1'h0, i == 11 ? 4'ha : i == 12 ? 4'h5 : i > 12 ? 4'h0 : 4'hf);
            up.drive(1'h1, 4'h0);
        end
        check("inReady full", 4'h0, {3'h0, inReady});
        check("stalled sectionOut", 4'hb, sectionOut);
        outReady = 1'h1;
        repeat (40) @(posedge clk);
        #1;
        check("drained sectionOut", 4'h9, sectionOut);
        check("drained fourthTap", 4'h1, {2'h0, fourthTap});
        check("drained halfTap", 4'h1, {3'h0, halfTap});
        check("inReady empty", 4'h1, {3'h0, inReady});
        // Mid-run reset clears the queue and the shift clock edge register, stages keep their data
        resetn = 1'h0;
        @(posedge clk);
        #1;
        resetn = 1'h1;
        settle();
        check("reset sectionOut", 4'h9, sectionOut);
        check("reset inReady", 4'h1, {3'h0, inReady});
        report_and_stop();
    end
endmodule // qss_shift_register_bench
`default_nettype wire

/* dv/qss_upstream.sv */
// Upstream model: drives the shift clock pin and the four serial data lines.
// Assumes pacing by the system clock; waits up to 100 clocks for inReady, then moves the shift clock anyway.
`timescale 1ns/1ps
`default_nettype none

module qss_upstream (
    input  wire logic                             clk,
    input  wire logic                             inReady,
    output logic                                  shiftClk,
    output logic [qss_pkg::NUM_SECTIONS-1:0]      serialIn
);
    initial begin
        shiftClk = 1'h0;
        serialIn = 4'h0;
    end

    // ========================================================
    // One shift clock change; clock stands still between calls
    task automatic drive(input logic lvl, input logic [qss_pkg::NUM_SECTIONS-1:0] d);
        int n;
        n = 0;
        while (inReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        // per-section data, chaining is left to outer wiring
        shiftClk = lvl;
        serialIn = d;
        @(posedge clk);
        #1;
        // Hold over: inverted data catches a late sample
        serialIn = ~d;
    endtask
endmodule // qss_upstream
`default_nettype wire

/* rtl/qss_fifo.sv */
// Event FIFO between the shift clock edge detector and the stage array.
// Assumes a single clock and an active low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module qss_fifo #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic             push;
    logic             pop;

    assign inReady  = (wrPtr_q[AW] == rdPtr_q[AW]) || (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]);
    assign outValid = (wrPtr_q != rdPtr_q);
    assign outData  = mem[rdPtr_q[AW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // ========================================================
    // Storage, no reset needed on data words
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    // ========================================================
    // Pointers carry a wrap bit so full and empty are exact
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_q <= '0;
        end else if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdPtr_q <= '0;
        end else if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

endmodule : qss_fifo

`default_nettype wire

/* rtl/qss_pkg.sv */
// Constants and types for the four-section serial shift register.
// Assumes one 50 MHz system clock; the shift clock arrives as a synchronous pin level.
// What this block does
// R1: Four independent sections: two of four stages, two of five stages.
// R2: Each five-stage section also presents its fourth stage on a tap.
// R3: Every section has its own serial input; no coupling between sections.
// R4: One shared shift clock moves every stage of all sections together.
// R5: On each falling shift clock edge each stage takes its predecessor's value.
// R6: Extra output follows a fourth-stage tap, updated on the rising edge.
// R7: Contents hold indefinitely while the shift clock stays high or low and no queued fall is left to pop.
// R8: Outside logic chains section outputs to inputs for up to 18 stages.
// R9: Cascading logic should prefer the half-cycle delayed tap under slow edges.
// R10: Stages have no reset; contents are unknown until data shifts through.
package qss_pkg;

    // ========================================================
    // Structure
    localparam int unsigned NUM_SECTIONS = 4;
    localparam int unsigned SHORT_LEN    = 4;
    localparam int unsigned LONG_LEN     = 5;
    localparam int unsigned TAP_STAGE    = 4;
    localparam int unsigned CHAIN_MAX    = 18;
    localparam int unsigned FIFO_DEPTH   = 32;

    // ========================================================
    // Reset values
    localparam logic SHIFT_CLK_RESET = 1'h0;

    // ========================================================
    // One queued shift clock edge with the serial inputs seen at it
    typedef struct packed {
        logic                    rise;
        logic [NUM_SECTIONS-1:0] din;
    } qss_event_t;

    localparam int unsigned EVENT_W = $bits(qss_event_t);

endpackage : qss_pkg

/* rtl/qss_section.sv */
// One serial shift section of STAGES stages, padded to the long section width.
// Assumes shiftEn is a one-cycle pulse per falling shift clock edge.
`timescale 1ns/1ps
`default_nettype none

module qss_section #(
    parameter int unsigned STAGES = 4
) (
    input  wire logic                       clk,
    input  wire logic                       shiftEn,
    input  wire logic                       serialIn,
    output logic [qss_pkg::LONG_LEN-1:0]    stages
);

    // ========================================================
    // Stage chain; no reset, contents are only data
    for (genvar s = 0; s < qss_pkg::LONG_LEN; s++) begin : g_stage
        if (s < STAGES) begin : g_live
            logic stage_q;
            // R10: no stage reset
            // R7: hold without shift
            always_ff @(posedge clk) begin
                if (shiftEn) begin
                    stage_q <= (s == 0) ? serialIn : stages[(s == 0) ? 0 : s-1];
                end
            end
            assign stages[s] = stage_q;
        end else begin : g_pad
            assign stages[s] = 1'h0;
        end
    end

endmodule : qss_section

`default_nettype wire

/* rtl/qss_shift_register.sv */
// Top of the four-section serial shift register, run on the system clock.
// Assumes shiftClk and serialIn are synchronous to clk; upstream honours inReady.
`timescale 1ns/1ps
`default_nettype none

module qss_shift_register (
    input  wire logic                               clk,
    input  wire logic                               resetn,
    input  wire logic                               shiftClk,
    input  wire logic [qss_pkg::NUM_SECTIONS-1:0]   serialIn,
    output logic                                    inReady,
    input  wire logic                               outReady,
    output logic      [qss_pkg::NUM_SECTIONS-1:0]   sectionOut,
    output logic      [1:0]                         fourthTap,
    output logic                                    halfTap
);

    logic                       shiftClk_q;
    logic                       edgeFall;
    logic                       edgeRise;
    logic                       evValid;
    qss_pkg::qss_event_t        evIn;
    qss_pkg::qss_event_t        evOut;
    logic                       evOutValid;
    logic                       popEv;
    logic                       popFall;
    logic                       popRise;
    logic [qss_pkg::LONG_LEN-1:0] stages [qss_pkg::NUM_SECTIONS];
    logic                       halfTap_q;

    // ========================================================
    // Shift clock edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shiftClk_q <= qss_pkg::SHIFT_CLK_RESET;
        end else begin
            shiftClk_q <= shiftClk;
        end
    end

    assign edgeFall   = shiftClk_q && !shiftClk;
    assign edgeRise   = !shiftClk_q && shiftClk;
    assign evValid    = edgeFall || edgeRise;
    assign evIn.rise  = edgeRise;
    assign evIn.din   = serialIn;

    // ========================================================
    // Edge queue; both edges go in so the half tap keeps its order
    // Edges seen while inReady is low are dropped: upstream must pause its clock
    qss_fifo #(
        .WIDTH (qss_pkg::EVENT_W),
        .DEPTH (qss_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (evValid),
        .inReady  (inReady),
        .inData   (evIn),
        .outValid (evOutValid),
        .outReady (outReady),
        .outData  (evOut)
    );

    assign popEv   = evOutValid && outReady;
    // R4: common shift pulse
    assign popFall = popEv && !evOut.rise;
    assign popRise = popEv && evOut.rise;

    // ========================================================
    // Sections: 0 and 1 short, 2 and 3 long
    // R1: section lengths chosen per index
    for (genvar k = 0; k < qss_pkg::NUM_SECTIONS; k++) begin : g_sec
        // R3: own serial input per section
        qss_section #(
            .STAGES ((k < 2) ? qss_pkg::SHORT_LEN : qss_pkg::LONG_LEN)
        ) u_sec (
            .clk      (clk),
            .shiftEn  (popFall),
            .serialIn (evOut.din[k]),
            .stages   (stages[k])
        );
        // R5: last stage drives the section output
        assign sectionOut[k] = stages[k][((k < 2) ? qss_pkg::SHORT_LEN : qss_pkg::LONG_LEN) - 1];
    end

    // R2: fourth-stage taps of the long sections
    assign fourthTap[0] = stages[2][qss_pkg::TAP_STAGE-1];
    assign fourthTap[1] = stages[3][qss_pkg::TAP_STAGE-1];

    // ========================================================
    // Half cycle delayed tap, no reset like the stages
    // R6: follows the tap on the rising edge
    always_ff @(posedge clk) begin
        if (popRise) begin
            halfTap_q <= stages[2][qss_pkg::TAP_STAGE-1];
        end
    end
    assign halfTap = halfTap_q;

    // ========================================================
    // Checks
    // Helper histories of section 0 and section 2 inputs, to watch the whole length
    logic [qss_pkg::SHORT_LEN-1:0] histA_q;
    logic [qss_pkg::LONG_LEN-1:0]  histC_q;
    logic [3:0]                    fallCnt_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            histA_q   <= '0;
            histC_q   <= '0;
            fallCnt_q <= '0;
        end else if (popFall) begin
            histA_q   <= {histA_q[qss_pkg::SHORT_LEN-2:0], evOut.din[0]};
            histC_q   <= {histC_q[qss_pkg::LONG_LEN-2:0], evOut.din[2]};
            fallCnt_q <= (fallCnt_q == 4'hf) ? fallCnt_q : fallCnt_q + 4'h1;
        end
    end

    sequence fall_s;
        popFall;
    endsequence

    sequence rise_s;
        popRise;
    endsequence

    // Stages are unknown until five falls have flushed them, so stage checks wait
    sequence warm_fall_s;
        fall_s ##0 (fallCnt_q >= 4'h5);
    endsequence

    sequence warm_rise_s;
        rise_s ##0 (fallCnt_q >= 4'h5);
    endsequence

    length_short_a: assert property ( // R1
        @(posedge clk) disable iff (!resetn)
        (fallCnt_q >= 4'h4) |-> (sectionOut[0] == histA_q[qss_pkg::SHORT_LEN-1])
    ) else $error("Short section length wrong");

    length_long_a: assert property ( // R1
        @(posedge clk) disable iff (!resetn)
        (fallCnt_q >= 4'h5) |-> (sectionOut[2] == histC_q[qss_pkg::LONG_LEN-1])
    ) else $error("Long section length wrong");

    tap_fourth_a: assert property ( // R2
        @(posedge clk) disable iff (!resetn)
        warm_fall_s |=> (fourthTap[0] == $past(stages[2][2])) && (fourthTap[1] == $past(stages[3][2]))
    ) else $error("Fourth stage tap wrong");

    inputs_apart_a: assert property ( // R3
        @(posedge clk) disable iff (!resetn)
        fall_s |=> (stages[0][0] == $past(evOut.din[0])) && (stages[1][0] == $past(evOut.din[1]))
                && (stages[3][0] == $past(evOut.din[3]))
    ) else $error("Section inputs coupled");

    shift_together_a: assert property ( // R4
        @(posedge clk) disable iff (!resetn)
        warm_fall_s |=> (stages[1][1] == $past(stages[1][0])) && (stages[3][4] == $past(stages[3][3]))
    ) else $error("Sections did not shift together");

    shift_chain_a: assert property ( // R5
        @(posedge clk) disable iff (!resetn)
        warm_fall_s |=> (stages[2][0] == $past(evOut.din[2])) && (stages[2][4] == $past(stages[2][3]))
    ) else $error("Stage chain did not shift");

    half_tap_a: assert property ( // R6
        @(posedge clk) disable iff (!resetn)
        warm_rise_s |=> (halfTap == $past(fourthTap[0]))
    ) else $error("Half tap did not follow");

    hold_still_a: assert property ( // R7
        @(posedge clk) disable iff (!resetn)
        (!popFall && (fallCnt_q >= 4'h5)) |=> ($stable(stages[0]) && $stable(stages[3]))
    ) else $error("Contents moved without a shift");

    no_reset_a: assert property ( // R10
        @(posedge clk)
        !resetn |-> (!popFall && !popRise)
    ) else $error("Stage changed under reset");

endmodule : qss_shift_register

`default_nettype wire
